/* core/step_indexer_pkg.sv */
// Constants, codes and register map shared by the step clock indexer.
// ****************************************************************
// What this block does
// [RULE_01] Each rising step clock edge advances the angle by one step of resolution.
// [RULE_02] A falling step clock edge changes neither angle nor winding setpoints.
// [RULE_03] Enable high drives windings; enable low turns all outputs off.
// [RULE_04] Host should hold enable low while the motor supply ramps.
// [RULE_05] Direction high: winding A leads B by 90 degrees; low: B leads A.
// [RULE_06] Reset high forces and holds the angle at the 45 degree home.
// [RULE_07] Host should hold reset high until the motor supply is valid.
// [RULE_08] Home setpoints: 100% full and half (a), 71% for the other resolutions.
// [RULE_09] While reset is applied, the home angle monitor is pulled low.
// [RULE_10] Step select code, bit 0 most significant, picks the step resolution.
// [RULE_11] All step selects low: standby, oscillator, outputs and bias off.
// [RULE_12] In standby the logic holds full step at 100% torque.
// [RULE_13] Entering standby clears the latched fault.
// [RULE_14] Power-up reset leaves the fault latch cleared.
// [RULE_15] Host sends no control edges for 10 us after standby exit.
// [RULE_16] Home monitor pin is open drain, low only at the home angle.
// [RULE_17] Fault pin is open drain, latched low after a fault.
// [RULE_18] Edges ignored in reset or standby; angle wraps in both directions.
// [RULE_19] Direction and resolution are sampled at each rising step edge.
// ****************************************************************
package step_indexer_pkg;

  typedef enum logic [2:0] {
    MODE_STANDBY = 3'h0,
    MODE_FULL    = 3'h1,
    MODE_HALF_A  = 3'h2,
    MODE_QUARTER = 3'h3,
    MODE_HALF_B  = 3'h4,
    MODE_EIGHTH  = 3'h5,
    MODE_SIXTEEN = 3'h6,
    MODE_THIRTY2 = 3'h7
  } step_mode_t;

  // Gray coded along standby -> wake -> run -> home hold.
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_WAKE    = 2'b01,
    ST_RUN     = 2'b11,
    ST_HOME    = 2'b10
  } power_state_t;

  localparam int         ANGLE_W      = 7;
  localparam int         THETA_W      = 6;
  localparam int         LEVEL_W      = 7;
  localparam logic [6:0] HOME_ANGLE   = 7'h10;
  localparam logic [5:0] QUADRANT_TOP = 6'h20;
  localparam logic [6:0] STEP_FULL    = 7'h20;
  localparam logic [6:0] STEP_HALF    = 7'h10;
  localparam logic [6:0] STEP_QUARTER = 7'h08;
  localparam logic [6:0] STEP_EIGHTH  = 7'h04;
  localparam logic [6:0] STEP_SIXTEEN = 7'h02;
  localparam logic [6:0] STEP_THIRTY2 = 7'h01;
  localparam logic [6:0] LEVEL_FULL   = 7'h64;
  localparam logic [5:0] THETA_HALF_A = 6'h10;
  localparam logic [5:0] THETA_QUART  = 6'h18;

  localparam int STARTUP_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] STARTUP_LAST = 9'(STARTUP_CYCLES - 1);

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK   = 8'h04;
  localparam logic [7:0] ADDR_STATE  = 8'h08;

  localparam int EVT_W       = 4;
  localparam int EVT_FAULT   = 0;
  localparam int EVT_HOME    = 1;
  localparam int EVT_STANDBY = 2;
  localparam int EVT_STEP    = 3;
  localparam logic [3:0] MASK_RESET = 4'h0;

  localparam int STATE_MODE_LSB = 8;
  localparam int STATE_FAULT    = 12;
  localparam int STATE_STANDBY  = 13;
  localparam int STATE_HOME     = 14;
  localparam int STATE_ENABLE   = 15;
  localparam int STATE_WAKE     = 16;

endpackage

/* core/current_ratio_lut.sv */
// Current ratio lookup for one winding within one quarter of the electrical cycle.
`timescale 1ns/1ns
module current_ratio_lut
  import step_indexer_pkg::*;
(
  input  wire step_indexer_pkg::step_mode_t mode,
  input  wire logic [THETA_W-1:0]           theta,
  output logic [LEVEL_W-1:0]                level
);

  function automatic logic [LEVEL_W-1:0] sine_ratio(input logic [THETA_W-1:0] t);
    logic [LEVEL_W-1:0] r;
    r = 7'h00;
    case (t)
      6'h00:   r = 7'd0;
      6'h01:   r = 7'd5;
      6'h02:   r = 7'd10;
      6'h03:   r = 7'd15;
      6'h04:   r = 7'd20;
      6'h05:   r = 7'd25;
      6'h06:   r = 7'd29;
      6'h07:   r = 7'd34;
      6'h08:   r = 7'd38;
      6'h09:   r = 7'd43;
      6'h0a:   r = 7'd47;
      6'h0b:   r = 7'd52;
      6'h0c:   r = 7'd56;
      6'h0d:   r = 7'd60;
      6'h0e:   r = 7'd63;
      6'h0f:   r = 7'd67;
      6'h10:   r = 7'd71;
      6'h11:   r = 7'd74;
      6'h12:   r = 7'd77;
      6'h13:   r = 7'd80;
      6'h14:   r = 7'd83;
      6'h15:   r = 7'd86;
      6'h16:   r = 7'd88;
      6'h17:   r = 7'd90;
      6'h18:   r = 7'd92;
      6'h19:   r = 7'd94;
      6'h1a:   r = 7'd96;
      6'h1b:   r = 7'd97;
      6'h1c:   r = 7'd98;
      6'h1d:   r = 7'd99;
      default: r = 7'd100;
    endcase
    return r;
  endfunction

  // Full step and half step (a) keep the diagonal at full torque; quarter step
  // lifts its upper point, so the coarse modes trade smoothness for torque.
  always_comb
  begin
    level = sine_ratio(theta);
    if (mode == MODE_FULL || mode == MODE_STANDBY)
    begin
      level = LEVEL_FULL;  // see [RULE_08] see [RULE_12]
    end
    else if (mode == MODE_HALF_A && theta == THETA_HALF_A)
    begin
      level = LEVEL_FULL;  // see [RULE_08]
    end
    else if (mode == MODE_QUARTER && theta == THETA_QUART)
    begin
      level = LEVEL_FULL;
    end
  end

endmodule

/* core/step_clock_indexer.sv */
// Step clock indexer: electrical angle, mode decode, fault latch and AHB-Lite status.
`timescale 1ns/1ns
module step_clock_indexer
  import step_indexer_pkg::*;
(
  input  wire  logic                    I_CLK,
  input  wire  logic                    I_SRST,
  input  wire  logic                    I_STEP_CLK,
  input  wire  logic                    I_ENABLE,
  input  wire  logic                    I_DIRECTION_SEL,
  input  wire  logic                    I_ANGLE_RESET,
  input  wire  logic                    I_STEP_SEL0,
  input  wire  logic                    I_STEP_SEL1,
  input  wire  logic                    I_STEP_SEL2,
  input  wire  logic                    I_OVERTEMPERATURE_SHUTDOWN,
  input  wire  logic                    I_OVERCURRENT_SHUTDOWN,
  input  wire  logic                    I_HSEL,
  input  wire  logic [7:0]              I_HADDR,
  input  wire  logic [1:0]              I_HTRANS,
  input  wire  logic                    I_HWRITE,
  input  wire  logic [2:0]              I_HSIZE,
  input  wire  logic [31:0]             I_HWDATA,
  input  wire  logic                    I_HREADY,
  output logic [31:0]                   O_HRDATA,
  output logic                          O_HREADYOUT,
  output logic                          O_HRESP,
  output logic                          O_IRQ,
  output logic [step_indexer_pkg::LEVEL_W-1:0] O_WINDING_A_LEVEL,
  output logic                          O_WINDING_A_NEG,
  output logic [step_indexer_pkg::LEVEL_W-1:0] O_WINDING_B_LEVEL,
  output logic                          O_WINDING_B_NEG,
  output logic                          O_OUTPUT_ENABLE,
  output logic                          O_OSC_ENABLE,
  output logic                          O_BIAS_ENABLE,
  output logic                          O_HOME_ANGLE_MONITOR_O,
  output logic                          O_HOME_ANGLE_MONITOR_OE,
  output logic                          O_FAULT_O,
  output logic                          O_FAULT_OE
);

  import step_indexer_pkg::*;

  // ****************************************************************
  // Pin decode
  // ****************************************************************
  step_mode_t   pin_mode;
  logic         pin_standby;

  assign pin_mode    = step_mode_t'({I_STEP_SEL0, I_STEP_SEL1, I_STEP_SEL2});  // see [RULE_10]
  assign pin_standby = (pin_mode == MODE_STANDBY);  // see [RULE_11]

  function automatic logic [ANGLE_W-1:0] step_size(input step_mode_t m);
    logic [ANGLE_W-1:0] s;
    s = STEP_FULL;
    case (m)
      MODE_FULL:    s = STEP_FULL;
      MODE_HALF_A:  s = STEP_HALF;
      MODE_HALF_B:  s = STEP_HALF;
      MODE_QUARTER: s = STEP_QUARTER;
      MODE_EIGHTH:  s = STEP_EIGHTH;
      MODE_SIXTEEN: s = STEP_SIXTEEN;
      MODE_THIRTY2: s = STEP_THIRTY2;
      default:      s = STEP_FULL;
    endcase
    return s;
  endfunction

  // ****************************************************************
  // Power state and stepping
  // ****************************************************************
  power_state_t       state;
  power_state_t       next_state;
  logic [8:0]         wake_count;
  logic [8:0]         next_wake_count;
  logic [ANGLE_W-1:0] angle;
  logic [ANGLE_W-1:0] next_angle;
  step_mode_t         mode;
  step_mode_t         next_mode;
  logic               step_prev;
  logic               step_rise;
  logic               step_taken;

  assign step_rise  = I_STEP_CLK & ~step_prev;  // see [RULE_01] see [RULE_02]
  assign step_taken = step_rise && (state == ST_RUN);  // see [RULE_18]

  always_comb
  begin
    next_state      = state;
    next_wake_count = wake_count;
    next_angle      = angle;
    next_mode       = mode;
    case (state)
      ST_STANDBY:
      begin
        next_angle = HOME_ANGLE;
        next_mode  = MODE_FULL;  // see [RULE_12]
        if (!pin_standby)
        begin
          next_state      = ST_WAKE;
          next_wake_count = 9'h000;
        end
      end
      ST_WAKE:
      begin
        // The restart window is the host's to respect; edges are not taken
        // here so a glitchy wake cannot move the rotor.
        next_angle      = HOME_ANGLE;
        next_wake_count = wake_count + 9'h001;  // see [RULE_15]
        if (pin_standby)
        begin
          next_state = ST_STANDBY;
        end
        else if (wake_count == STARTUP_LAST)
        begin
          next_state = I_ANGLE_RESET ? ST_HOME : ST_RUN;
          next_mode  = pin_mode;
        end
      end
      ST_RUN:
      begin
        if (pin_standby)
        begin
          next_state = ST_STANDBY;
          next_angle = HOME_ANGLE;
          next_mode  = MODE_FULL;
        end
        else if (I_ANGLE_RESET)
        begin
          next_state = ST_HOME;
          next_angle = HOME_ANGLE;  // see [RULE_06]
          next_mode  = pin_mode;
        end
        else if (step_rise)
        begin
          next_mode = pin_mode;  // see [RULE_19]
          if (I_DIRECTION_SEL)
          begin
            next_angle = angle + step_size(pin_mode);  // see [RULE_01] see [RULE_18]
          end
          else
          begin
            next_angle = angle - step_size(pin_mode);  // see [RULE_05] see [RULE_18]
          end
        end
      end
      ST_HOME:
      begin
        next_angle = HOME_ANGLE;  // see [RULE_06]
        next_mode  = pin_mode;
        if (pin_standby)
        begin
          next_state = ST_STANDBY;
          next_mode  = MODE_FULL;
        end
        else if (!I_ANGLE_RESET)
        begin
          next_state = ST_RUN;
        end
      end
      default:
      begin
        next_state = ST_STANDBY;
        next_angle = HOME_ANGLE;
        next_mode  = MODE_FULL;
      end
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      state      <= ST_STANDBY;
      wake_count <= 9'h000;
      angle      <= HOME_ANGLE;
      mode       <= MODE_FULL;
      step_prev  <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      wake_count <= next_wake_count;
      angle      <= next_angle;
      mode       <= next_mode;
      step_prev  <= I_STEP_CLK;
    end
  end

  // ****************************************************************
  // Winding setpoints
  // ****************************************************************
  logic [1:0]         quadrant;
  logic [THETA_W-1:0] fine;
  logic [THETA_W-1:0] theta_a;
  logic [THETA_W-1:0] theta_b;
  logic [LEVEL_W-1:0] level_a;
  logic [LEVEL_W-1:0] level_b;

  // Winding A follows cosine and B sine, so counting up puts A ahead by 90 degrees.
  assign quadrant = next_angle[6:5];
  assign fine     = {1'b0, next_angle[4:0]};
  assign theta_a  = quadrant[0] ? fine : QUADRANT_TOP - fine;  // see [RULE_05]
  assign theta_b  = quadrant[0] ? QUADRANT_TOP - fine : fine;

  current_ratio_lut ratio_a (
    .mode  (next_mode),
    .theta (theta_a),
    .level (level_a)
  );

  current_ratio_lut ratio_b (
    .mode  (next_mode),
    .theta (theta_b),
    .level (level_b)
  );

  // ****************************************************************
  // Fault latch
  // ****************************************************************
  logic fault;
  logic next_fault;
  logic fault_set;
  logic standby_entry;

  assign fault_set     = (I_OVERTEMPERATURE_SHUTDOWN | I_OVERCURRENT_SHUTDOWN) && !pin_standby;
  assign standby_entry = pin_standby && (state != ST_STANDBY);

  // A fault seen in the cycle of standby entry is masked by pin_standby and does not survive it.
  always_comb
  begin
    next_fault = fault;
    if (standby_entry)
    begin
      next_fault = 1'b0;  // see [RULE_13]
    end
    if (fault_set)
    begin
      next_fault = 1'b1;  // see [RULE_17]
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      fault <= 1'b0;  // see [RULE_14]
    end
    else
    begin
      fault <= next_fault;
    end
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  logic next_home;

  assign next_home = (next_angle == HOME_ANGLE);

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_WINDING_A_LEVEL       <= LEVEL_FULL;
      O_WINDING_A_NEG         <= 1'b0;
      O_WINDING_B_LEVEL       <= LEVEL_FULL;
      O_WINDING_B_NEG         <= 1'b0;
      O_OUTPUT_ENABLE         <= 1'b0;
      O_OSC_ENABLE            <= 1'b0;
      O_BIAS_ENABLE           <= 1'b0;
      O_HOME_ANGLE_MONITOR_O  <= 1'b0;
      O_HOME_ANGLE_MONITOR_OE <= 1'b1;
      O_FAULT_O               <= 1'b0;
      O_FAULT_OE              <= 1'b0;
    end
    else
    begin
      O_WINDING_A_LEVEL       <= level_a;  // see [RULE_08]
      O_WINDING_A_NEG         <= (quadrant == 2'd1) || (quadrant == 2'd2);
      O_WINDING_B_LEVEL       <= level_b;
      O_WINDING_B_NEG         <= quadrant[1];
      O_OUTPUT_ENABLE         <= I_ENABLE && !pin_standby;  // see [RULE_03] see [RULE_11]
      O_OSC_ENABLE            <= !pin_standby;  // see [RULE_11]
      O_BIAS_ENABLE           <= !pin_standby;
      O_HOME_ANGLE_MONITOR_O  <= 1'b0;
      O_HOME_ANGLE_MONITOR_OE <= next_home;  // see [RULE_16] see [RULE_09]
      O_FAULT_O               <= 1'b0;
      O_FAULT_OE              <= next_fault;  // see [RULE_17]
    end
  end

  // ****************************************************************
  // Event status and interrupt
  // ****************************************************************
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] next_mask;
  logic [EVT_W-1:0] events;
  logic             home_now;

  assign home_now = (angle == HOME_ANGLE);

  always_comb
  begin
    events              = '0;
    events[EVT_FAULT]   = next_fault && !fault;
    events[EVT_HOME]    = next_home && !home_now;
    events[EVT_STANDBY] = standby_entry;
    events[EVT_STEP]    = step_taken;
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic       wr_pend;
  logic       next_wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic       rd_take;
  logic [31:0] next_hrdata;
  logic [31:0] state_word;

  assign rd_take = I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE;

  always_comb
  begin
    state_word                                = 32'h0000_0000;
    state_word[ANGLE_W-1:0]                   = angle;
    state_word[STATE_MODE_LSB +: 3]           = mode;
    state_word[STATE_FAULT]                   = fault;
    state_word[STATE_STANDBY]                 = (state == ST_STANDBY);
    state_word[STATE_HOME]                    = home_now;
    state_word[STATE_ENABLE]                  = O_OUTPUT_ENABLE;
    state_word[STATE_WAKE]                    = (state == ST_WAKE);
  end

  always_comb
  begin
    next_wr_pend = I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE;
    next_wr_addr = I_HADDR;
    next_hrdata  = 32'h0000_0000;
    next_mask    = mask;
    next_status  = status;
    if (rd_take)
    begin
      case (I_HADDR)
        ADDR_STATUS:
        begin
          next_hrdata[EVT_W-1:0] = status;
          next_status            = '0;
        end
        ADDR_MASK:   next_hrdata[EVT_W-1:0] = mask;
        ADDR_STATE:  next_hrdata = state_word;
        default:     next_hrdata = 32'h0000_0000;
      endcase
    end
    if (wr_pend && wr_addr == ADDR_MASK)
    begin
      next_mask = I_HWDATA[EVT_W-1:0];
    end
    next_status = next_status | events;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      status      <= '0;
      mask        <= MASK_RESET;
      O_HRDATA    <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      O_IRQ       <= 1'b0;
    end
    else
    begin
      wr_pend     <= next_wr_pend;
      wr_addr     <= next_wr_addr;
      status      <= next_status;
      mask        <= next_mask;
      O_HRDATA    <= next_hrdata;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      O_IRQ       <= |(next_status & next_mask);
    end
  end

endmodule

/* tb/host_model.sv */
// Host controller model driving the step, direction, angle reset, enable and mode pins.
`timescale 1ns/1ns
module host_model
  import step_indexer_pkg::*;
(
  input  wire logic       i_clk,
  output logic            o_step_clk,
  output logic            o_direction_sel,
  output logic            o_angle_reset,
  output logic            o_enable,
  output logic [2:0]      o_step_sel
);
  // ****
  // Pin sequencing
  // ****
  // The supply ramps at time zero, so the stage starts off and the angle held.
  initial
  begin
    o_step_clk      = 1'b0;
    o_direction_sel = 1'b1;
    o_angle_reset   = 1'b1;
    o_enable        = 1'b0;
    o_step_sel      = 3'h0;
  end

  task automatic set_mode(input logic [2:0] mode);
    logic waking;
    waking = (o_step_sel == 3'h0) && (mode != 3'h0);
    @(posedge i_clk);
    o_step_sel <= mode;
    if (waking)
      repeat (STARTUP_CYCLES + 4) @(posedge i_clk);
  endtask

  task automatic step(input logic dir, input int hold);
    @(posedge i_clk);
    o_direction_sel <= dir;
    o_step_clk      <= 1'b1;
    repeat (hold) @(posedge i_clk);
    o_step_clk <= 1'b0;
    repeat (hold) @(posedge i_clk);
  endtask

  task automatic hold_home(input logic on);
    @(posedge i_clk);
    o_angle_reset <= on;
  endtask

  task automatic set_enable(input logic on);
    @(posedge i_clk);
    o_enable <= on;
  endtask
endmodule

/* tb/step_indexer_props.sv */
// Checker of the step clock indexer pin behaviour, bound to the top module.
`timescale 1ns/1ns
module step_indexer_props
  import step_indexer_pkg::*;
(
  input logic       I_CLK,
  input logic       I_SRST,
  input logic       I_STEP_CLK,
  input logic       I_ENABLE,
  input logic       I_ANGLE_RESET,
  input logic       I_STEP_SEL0,
  input logic       I_STEP_SEL1,
  input logic       I_STEP_SEL2,
  input logic       I_OVERTEMPERATURE_SHUTDOWN,
  input logic       I_OVERCURRENT_SHUTDOWN,
  input logic [6:0] O_WINDING_A_LEVEL,
  input logic       O_WINDING_A_NEG,
  input logic [6:0] O_WINDING_B_LEVEL,
  input logic       O_WINDING_B_NEG,
  input logic       O_OUTPUT_ENABLE,
  input logic       O_OSC_ENABLE,
  input logic       O_BIAS_ENABLE,
  input logic       O_HOME_ANGLE_MONITOR_O,
  input logic       O_HOME_ANGLE_MONITOR_OE,
  input logic       O_FAULT_O,
  input logic       O_FAULT_OE
);
  logic [2:0] sel;
  assign sel = {I_STEP_SEL0, I_STEP_SEL1, I_STEP_SEL2};

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  // ****
  // Properties
  // ****
  sequence held_home;
    (I_ANGLE_RESET && $stable(sel))[*3];
  endsequence
  sequence fault_seen;
    ((I_OVERTEMPERATURE_SHUTDOWN || I_OVERCURRENT_SHUTDOWN) && sel != 3'h0)
      ##1 (sel != 3'h0)[*2];
  endsequence

  standby_off_a: assert property (
    1'b1 |=> {O_OSC_ENABLE, O_BIAS_ENABLE} == {2{$past(sel != 3'h0)}})
    else $error("osc or bias wrong");
  enable_follow_a: assert property (
    1'b1 |=> O_OUTPUT_ENABLE == $past(I_ENABLE && sel != 3'h0))
    else $error("output enable wrong");
  fall_steady_a: assert property (
    $fell(I_STEP_CLK) && !I_ANGLE_RESET && !$past(I_ANGLE_RESET)
      && !$past(I_ANGLE_RESET, 2) && $stable(sel) && sel != 3'h0
    |=> $stable({O_WINDING_A_LEVEL, O_WINDING_A_NEG, O_WINDING_B_LEVEL, O_WINDING_B_NEG}))
    else $error("setpoints moved on fall");
  home_mon_a: assert property (
    held_home |=> O_HOME_ANGLE_MONITOR_OE)
    else $error("home monitor released");
  home_full_a: assert property (
    held_home ##0 (sel < 3'h3) |=> O_WINDING_A_LEVEL == LEVEL_FULL
      && O_WINDING_B_LEVEL == LEVEL_FULL)
    else $error("home level not full");
  home_part_a: assert property (
    held_home ##0 (sel > 3'h2) |=> O_WINDING_A_LEVEL == 7'h47 && O_WINDING_B_LEVEL == 7'h47
      && !O_WINDING_A_NEG && !O_WINDING_B_NEG)
    else $error("home level not 71");
  open_drain_a: assert property (
    !O_HOME_ANGLE_MONITOR_O && !O_FAULT_O)
    else $error("open drain driven high");
  fault_set_a: assert property (
    fault_seen |-> O_FAULT_OE)
    else $error("fault not latched");
  fault_hold_a: assert property (
    O_FAULT_OE && sel != 3'h0 && $past(sel) != 3'h0 |=> O_FAULT_OE)
    else $error("fault lost");
  standby_clear_a: assert property (
    (sel == 3'h0)[*3] |-> !O_FAULT_OE)
    else $error("fault kept in standby");
endmodule

bind step_clock_indexer step_indexer_props props_inst (.*);

/* tb/tb.sv */
// Self-checking testbench of the step clock indexer with a host pin model.
`timescale 1ns/1ns
module tb import step_indexer_pkg::*;;
  typedef struct packed
  {
    logic [2:0] sel;
    logic       dir;
    logic [6:0] a;
    logic [6:0] b;
    logic       na;
    logic       nb;
  } row_t;

  logic        clk, srst, step_clk, dir_sel, angle_rst, enable, over_temp, over_cur;
  logic [2:0]  sel;
  logic        hsel, hwrite, hreadyout, hresp, irq, a_neg, b_neg;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [6:0]  a_level, b_level, home_lvl;
  logic        out_en, osc_en, bias_en, home_o, home_oe, fault_o, fault_oe;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  row_t        rows [9] = '{
    '{3'h1, 1'b1, 7'h64, 7'h64, 1'b1, 1'b0}, '{3'h1, 1'b0, 7'h64, 7'h64, 1'b0, 1'b1},
    '{3'h2, 1'b1, 7'h00, 7'h64, 1'b1, 1'b0}, '{3'h2, 1'b0, 7'h64, 7'h00, 1'b0, 1'b0},
    '{3'h3, 1'b1, 7'h26, 7'h64, 1'b0, 1'b0}, '{3'h4, 1'b1, 7'h00, 7'h64, 1'b1, 1'b0},
    '{3'h5, 1'b1, 7'h38, 7'h53, 1'b0, 1'b0}, '{3'h6, 1'b1, 7'h3f, 7'h4d, 1'b0, 1'b0},
    '{3'h7, 1'b1, 7'h43, 7'h4a, 1'b0, 1'b0}};

  step_clock_indexer step_clock_indexer_inst (
    .I_CLK(clk), .I_SRST(srst), .I_STEP_CLK(step_clk), .I_ENABLE(enable),
    .I_DIRECTION_SEL(dir_sel), .I_ANGLE_RESET(angle_rst), .I_STEP_SEL0(sel[2]),
    .I_STEP_SEL1(sel[1]), .I_STEP_SEL2(sel[0]), .I_OVERTEMPERATURE_SHUTDOWN(over_temp),
    .I_OVERCURRENT_SHUTDOWN(over_cur), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hreadyout),
    .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .O_IRQ(irq),
    .O_WINDING_A_LEVEL(a_level), .O_WINDING_A_NEG(a_neg), .O_WINDING_B_LEVEL(b_level),
    .O_WINDING_B_NEG(b_neg), .O_OUTPUT_ENABLE(out_en), .O_OSC_ENABLE(osc_en),
    .O_BIAS_ENABLE(bias_en), .O_HOME_ANGLE_MONITOR_O(home_o),
    .O_HOME_ANGLE_MONITOR_OE(home_oe), .O_FAULT_O(fault_o), .O_FAULT_OE(fault_oe));

  host_model host_model_inst (.i_clk(clk), .o_step_clk(step_clk), .o_direction_sel(dir_sel),
    .o_angle_reset(angle_rst), .o_enable(enable), .o_step_sel(sel));

  // ****
  // Helpers
  // ****
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The run needs about eight hundred cycles; a wedged handshake ends it here.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures = failures + 1;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      failures = failures + 1;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= addr;
    hwrite <= wr;
    hsize  <= {1'b0, wr, 1'b0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask

  // ****
  // Tests
  // ****
  initial
  begin
    srst = 1'b1;
    {over_temp, over_cur, hsel, hwrite} = 4'h0;
    {haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check("reset", 32'({1'b1, 4'h0, LEVEL_FULL, LEVEL_FULL}), 32'({home_oe, fault_oe, out_en,
      osc_en, bias_en, a_level, b_level}));
    host_model_inst.hold_home(1'b0);
    host_model_inst.step(1'b1, 1);
    check("standby step", 32'h1, 32'(home_oe));
    $display("test reset done");
    host_model_inst.set_enable(1'b1);
    host_model_inst.set_mode(3'h1);
    check("stage on", 32'h7, 32'({out_en, osc_en, bias_en}));
    foreach (rows[i])
    begin
      host_model_inst.set_mode(rows[i].sel);
      host_model_inst.hold_home(1'b1);
      repeat (4) @(posedge clk);
      home_lvl = (rows[i].sel < 3'h3) ? LEVEL_FULL : 7'h47;
      check("home", 32'({1'b1, home_lvl, home_lvl, 2'b00}), 32'({home_oe, a_level,
        b_level, a_neg, b_neg}));
      host_model_inst.hold_home(1'b0);
      repeat (2) @(posedge clk);
      host_model_inst.step(rows[i].dir, 1);
      check("step", 32'({rows[i].a, rows[i].b, rows[i].na, rows[i].nb, 1'b0}), 32'({a_level,
        b_level, a_neg, b_neg, home_oe}));
    end
    $display("test resolution table done");
    host_model_inst.hold_home(1'b1);
    host_model_inst.step(1'b1, 2);
    check("held step", 32'h1, 32'(home_oe));
    host_model_inst.hold_home(1'b0);
    repeat (2) @(posedge clk);
    repeat (17) host_model_inst.step(1'b0, 2);
    check("wrap down", 32'({LEVEL_FULL, 7'h05, 2'b01}),
      32'({a_level, b_level, a_neg, b_neg}));
    host_model_inst.step(1'b1, 1);
    check("wrap up", 32'({LEVEL_FULL, 7'h00, 2'b00}),
      32'({a_level, b_level, a_neg, b_neg}));
    host_model_inst.set_enable(1'b0);
    repeat (2) @(posedge clk);
    check("enable off", 32'h0, 32'(out_en));
    host_model_inst.set_enable(1'b1);
    $display("test wrap and enable done");
    bus(1'b1, ADDR_MASK, 32'h8, rd);
    bus(1'b0, ADDR_MASK, 32'h0, rd);
    check("mask", 32'h8, rd);
    bus(1'b0, ADDR_STATUS, 32'h0, rd);
    host_model_inst.step(1'b1, 1);
    repeat (2) @(posedge clk);
    check("irq raised", 32'h1, 32'(irq));
    bus(1'b0, ADDR_STATUS, 32'h0, rd);
    check("step event", 32'h8, rd & 32'h8);
    repeat (2) @(posedge clk);
    check("irq cleared", 32'h0, 32'(irq));
    bus(1'b1, ADDR_MASK, 32'h0, rd);
    host_model_inst.step(1'b1, 1);
    repeat (2) @(posedge clk);
    check("irq masked", 32'h0, 32'(irq));
    bus(1'b1, 8'h0c, 32'hffff_ffff, rd);
    bus(1'b0, 8'h0c, 32'h0, rd);
    check("unmapped", 32'h0, rd | 32'(hresp));
    $display("test registers done");
    over_temp <= 1'b1;
    @(posedge clk);
    over_temp <= 1'b0;
    repeat (3) @(posedge clk);
    check("fault set", 32'h1, 32'(fault_oe));
    host_model_inst.set_mode(3'h0);
    repeat (3) @(posedge clk);
    check("standby", 32'({4'h0, LEVEL_FULL, LEVEL_FULL}), 32'({fault_oe, out_en, osc_en,
      bias_en, a_level, b_level}));
    host_model_inst.set_mode(3'h5);
    over_cur <= 1'b1;
    @(posedge clk);
    over_cur <= 1'b0;
    repeat (3) @(posedge clk);
    check("overcurrent", 32'h1, 32'(fault_oe));
    $display("test faults done");
    stop_test();
  end
endmodule
